// [hdl/sync_slave_defs.svh]
// Constants of the synchronous slave serial port: register map, fields, reset values.
// Overview of operation
// [R1] Software selects slave: clocked mode, enable, clock-source-master clear.
// [R2] Software disables analog function on clock, data pins.
// [R3] Ninth-bit enable captures 9-bit words, MSB in status.
// [R4] Receive data read returns low 8 bits from FIFO.
// [R5] Reception runs only while continuous receive enable set.
// [R6] Word done sets receive flag; request needs enable.
// [R7] Overrun holds until receive or port enable cleared.
// [R8] Only synchronous slave mode keeps shifting in sleep.
// [R9] Shift registers advance only on external serial clock.
// [R10] Software empties receive FIFO before sleeping to receive.
// [R11] External master supplies clock and data during sleep.
// [R12] Word received in sleep sets flag, wakes processor.
// [R13] Wake resumes next instruction; global enable calls vector.
// [R14] Software fills shift register and buffer before sleeping.
// [R15] Software sets transmit and peripheral enables before sleeping.
// [R16] Shift done: buffered byte moves in, transmit flag sets.
// [R17] Writing transmit data clears transmit flag.
// [R18] Receive request needs receive, peripheral, global enables.
// [R19] Software reads ninth bit before the low byte.
// [R20] Slave reception continuous; single receive enable ignored.
// [R21] One bit per clock period, polarity picks edge.
`ifndef SYNC_SLAVE_DEFS_SVH
`define SYNC_SLAVE_DEFS_SVH

// Register indices on the plain port.
`define RX_CTRL_IDX 3'h0
`define TX_CTRL_IDX 3'h1
`define BAUD_CTRL_IDX 3'h2
`define RX_DATA_IDX 3'h3
`define TX_DATA_IDX 3'h4
`define IRQ_CTRL_IDX 3'h5

// Receive status and control fields.
`define RX_PORT_EN_BIT 7
`define RX_NINTH_EN_BIT 6
`define RX_SINGLE_EN_BIT 5
`define RX_CONT_EN_BIT 4
`define RX_OVERRUN_BIT 1
`define RX_NINTH_BIT 0

// Transmit status and control fields.
`define TX_CLK_MASTER_BIT 7
`define TX_NINTH_EN_BIT 6
`define TX_EN_BIT 5
`define TX_SYNC_BIT 4
`define TX_SHIFT_EMPTY_BIT 1
`define TX_NINTH_BIT 0

// Baud control fields.
`define BAUD_RX_IDLE_BIT 6
`define BAUD_CLK_POL_BIT 4

// Interrupt control fields.
`define IRQ_GLOBAL_EN_BIT 7
`define IRQ_PERIPH_EN_BIT 6
`define IRQ_RX_EN_BIT 5
`define IRQ_TX_EN_BIT 4
`define IRQ_RX_FLAG_BIT 1
`define IRQ_TX_FLAG_BIT 0

// Reset values.
`define CTRL_RESET 8'h00
`define WORD_RESET 9'h000
`define RX_DEPTH_DEFAULT 2

// Word lengths in bits.
`define WORD_LEN_8 4'h8
`define WORD_LEN_9 4'h9

`endif

// [hdl/sync_slave_pkg.sv]
// Types of the synchronous slave serial port.
package sync_slave_pkg;
  typedef logic [8:0] word_t;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] bit_count_t;
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SHIFTING
  } tx_state_t;
endpackage

// [hdl/sync_slave_serial_port.sv]
// Synchronous slave serial port: register port, receive FIFO, shift logic.
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "sync_slave_defs.svh"
module sync_slave_serial_port #(
  parameter int RX_DEPTH = `RX_DEPTH_DEFAULT
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port.
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Serial pins.
  input wire logic serialClkPin,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  // Processor power state and wake.
  input wire logic sleepMode,
  output logic wakeRequest,
  output logic vectorCall
);

  localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;

  initial begin
    if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin
      $error("RX_DEPTH must be a power of two of at least 2.");
    end
  end

  function automatic sync_slave_pkg::bit_count_t wordLen(input logic ninth);
    wordLen = ninth ? `WORD_LEN_9 : `WORD_LEN_8;
  endfunction

  function automatic logic addrHit(input logic [2:0] a, input logic [2:0] idx);
    addrHit = (a == idx);
  endfunction

  // Software-held control registers.
  logic [7:0] rxCtrl_reg;
  logic [7:0] txCtrl_reg;
  logic [7:0] baudCtrl_reg;
  logic [7:0] irqCtrl_reg;
  // Pin synchronisers.
  logic clkS1_reg, clkS2_reg, clkS3_reg, clkLevel_reg;
  logic datS1_reg, datS2_reg, datS3_reg, datLevel_reg;
  // Receive path.
  sync_slave_pkg::word_t rxShift_reg;
  sync_slave_pkg::bit_count_t rxCnt_reg;
  sync_slave_pkg::word_t rxFifo [RX_DEPTH];
  logic [PTR_W-1:0] rdPtr_reg, wrPtr_reg;
  logic [PTR_W:0] fillCnt_reg;
  logic overrun_reg;
  // Transmit path.
  sync_slave_pkg::tx_state_t txState_reg;
  sync_slave_pkg::word_t txShift_reg;
  sync_slave_pkg::bit_count_t txCnt_reg;
  sync_slave_pkg::word_t txBuf_reg;
  logic txBufFull_reg;

  // Decoding.
  wire wrRxCtrl = regWrite && addrHit(regAddr, `RX_CTRL_IDX);
  wire wrTxCtrl = regWrite && addrHit(regAddr, `TX_CTRL_IDX);
  wire wrBaud = regWrite && addrHit(regAddr, `BAUD_CTRL_IDX);
  wire wrTxData = regWrite && addrHit(regAddr, `TX_DATA_IDX);
  wire wrIrq = regWrite && addrHit(regAddr, `IRQ_CTRL_IDX);
  wire rdRxData = regRead && addrHit(regAddr, `RX_DATA_IDX);

  wire portEn = rxCtrl_reg[`RX_PORT_EN_BIT];
  wire contEn = rxCtrl_reg[`RX_CONT_EN_BIT];
  wire singleEn = rxCtrl_reg[`RX_SINGLE_EN_BIT];
  wire rxNinth = rxCtrl_reg[`RX_NINTH_EN_BIT];
  wire txNinth = txCtrl_reg[`TX_NINTH_EN_BIT];
  wire clkPol = baudCtrl_reg[`BAUD_CLK_POL_BIT];
  // The port only shifts as a clocked-mode slave; other modes would need
  // the system clock, which is gone in sleep, so they never shift here.
  wire slaveMode = portEn && txCtrl_reg[`TX_SYNC_BIT]
    && !txCtrl_reg[`TX_CLK_MASTER_BIT]; // [R1] [R8]
  // A port disable resets all serial state but the FIFO storage and the pin synchronisers.
  wire portReset = !portEn; // [R7]

  // Serial clock edges, seen once the second and third stages agree.
  wire clkStable = (clkS2_reg == clkS3_reg);
  wire clkRise = clkStable && clkS3_reg && !clkLevel_reg;
  wire clkFall = clkStable && !clkS3_reg && clkLevel_reg;
  wire datStable = (datS2_reg == datS3_reg);
  wire datNext = datStable ? datS3_reg : datLevel_reg;
  // Data is sampled on one edge and launched on the other.
  wire sampleEdge = slaveMode && (clkPol ? clkFall : clkRise); // [R9] [R21]
  wire launchEdge = slaveMode && (clkPol ? clkRise : clkFall); // [R9] [R21]

  // Receive decisions; the single receive enable plays no part.
  wire rxEnable = slaveMode && contEn; // [R5] [R20]
  wire rxActive = rxEnable && !overrun_reg;
  wire rxLastBit = (rxCnt_reg == wordLen(rxNinth) - 4'h1);
  wire rxWordDone = rxActive && sampleEdge && rxLastBit;
  wire fifoFull = (fillCnt_reg == RX_DEPTH[PTR_W:0]);
  wire fifoEmpty = (fillCnt_reg == '0);
  wire rxPush = rxWordDone && !fifoFull;
  wire rxOverflow = rxWordDone && fifoFull;
  wire rxPop = rdRxData && !fifoEmpty;
  // Bits enter at the top and move down, so the first bit ends at bit 0.
  wire [8:0] rxShifted = {datNext, rxShift_reg[8:1]}; // [R21]
  wire [8:0] rxWord = rxNinth ? rxShifted : {1'b0, rxShifted[8:1]}; // [R3]
  sync_slave_pkg::word_t fifoHead;
  // An empty FIFO reads as zero, since its storage has no reset.
  assign fifoHead = fifoEmpty ? sync_slave_pkg::word_t'(0) : rxFifo[rdPtr_reg];
  wire rxFlag = !fifoEmpty; // [R6] [R12]

  // Transmit decisions.
  wire txModeSel = slaveMode && txCtrl_reg[`TX_EN_BIT] && !contEn && !singleEn;
  wire txLastBit = (txCnt_reg == wordLen(txNinth) - 4'h1);
  wire txWordDone = (txState_reg == sync_slave_pkg::TX_SHIFTING) && sampleEdge && txLastBit;
  wire txShiftFree = (txState_reg == sync_slave_pkg::TX_IDLE) || txWordDone;
  wire txLoad = txModeSel && txShiftFree && txBufFull_reg; // [R16]
  wire txFlag = !txBufFull_reg; // [R16] [R17]
  wire [8:0] txWord = {txCtrl_reg[`TX_NINTH_BIT], regWrData};
  wire txShiftEmpty = (txState_reg == sync_slave_pkg::TX_IDLE);

  // Interrupt requests toward the processor.
  wire rxIrq = rxFlag && irqCtrl_reg[`IRQ_RX_EN_BIT]; // [R6]
  wire txIrq = txFlag && irqCtrl_reg[`IRQ_TX_EN_BIT];
  wire periphIrq = (rxIrq || txIrq) && irqCtrl_reg[`IRQ_PERIPH_EN_BIT]; // [R18]
  wire vectorNext = periphIrq && irqCtrl_reg[`IRQ_GLOBAL_EN_BIT]; // [R13] [R18]

  // Read data selection.
  wire [7:0] rxCtrlView = {rxCtrl_reg[7:4], 2'b00, overrun_reg, fifoHead[8]}; // [R3] [R7]
  wire [7:0] txCtrlView = {txCtrl_reg[7:4], 1'b0, txCtrl_reg[2], txShiftEmpty,
    txCtrl_reg[0]};
  wire [7:0] baudView = {1'b0, !(rxActive && rxCnt_reg != '0), 1'b0,
    baudCtrl_reg[4:0]};
  wire [7:0] irqView = {irqCtrl_reg[7:4], 2'b00, rxFlag, txFlag};
  wire [7:0] rdMux =
    addrHit(regAddr, `RX_CTRL_IDX) ? rxCtrlView :
    addrHit(regAddr, `TX_CTRL_IDX) ? txCtrlView :
    addrHit(regAddr, `BAUD_CTRL_IDX) ? baudView :
    addrHit(regAddr, `RX_DATA_IDX) ? fifoHead[7:0] : // [R4]
    addrHit(regAddr, `IRQ_CTRL_IDX) ? irqView : 8'h00;

  // Control registers.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxCtrl_reg <= `CTRL_RESET;
      txCtrl_reg <= `CTRL_RESET;
      baudCtrl_reg <= `CTRL_RESET;
      irqCtrl_reg <= `CTRL_RESET;
    end else begin
      if (wrRxCtrl) begin
        rxCtrl_reg <= {regWrData[7:4], 4'h0};
      end
      if (wrTxCtrl) begin
        txCtrl_reg <= {regWrData[7:4], 1'b0, regWrData[2], 1'b0, regWrData[0]};
      end
      if (wrBaud) begin
        baudCtrl_reg <= {3'h0, regWrData[4:0]};
      end
      if (wrIrq) begin
        irqCtrl_reg <= {regWrData[7:4], 4'h0};
      end
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= regRead ? rdMux : 8'h00;
    end
  end

  // Three-stage synchronisers; the debounced level follows agreement.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clkS1_reg <= 1'b0;
      clkS2_reg <= 1'b0;
      clkS3_reg <= 1'b0;
      clkLevel_reg <= 1'b0;
      datS1_reg <= 1'b0;
      datS2_reg <= 1'b0;
      datS3_reg <= 1'b0;
      datLevel_reg <= 1'b0;
    end else begin
      clkS1_reg <= serialClkPin;
      clkS2_reg <= clkS1_reg;
      clkS3_reg <= clkS2_reg;
      clkLevel_reg <= clkStable ? clkS3_reg : clkLevel_reg;
      datS1_reg <= serialDataIn;
      datS2_reg <= datS1_reg;
      datS3_reg <= datS2_reg;
      datLevel_reg <= datNext;
    end
  end

  // Receive shift register and bit count.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxShift_reg <= `WORD_RESET;
      rxCnt_reg <= '0;
    end else if (portReset || !rxActive) begin
      rxShift_reg <= `WORD_RESET;
      rxCnt_reg <= '0;
    end else if (sampleEdge) begin
      rxShift_reg <= rxShifted; // [R9] [R21]
      rxCnt_reg <= rxLastBit ? 4'h0 : rxCnt_reg + 4'h1; // [R3]
    end
  end

  // Receive FIFO storage; words hold nine bits, the ninth read separately.
  always_ff @(posedge sys_clk) begin
    if (rxPush) begin
      rxFifo[wrPtr_reg] <= rxWord; // [R3] [R6]
    end
  end

  // FIFO pointers; a push and a pop in one cycle keep the fill count.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdPtr_reg <= '0;
      wrPtr_reg <= '0;
      fillCnt_reg <= '0;
    end else if (portReset) begin
      rdPtr_reg <= '0;
      wrPtr_reg <= '0;
      fillCnt_reg <= '0;
    end else begin
      if (rxPush) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (rxPop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1; // [R4]
      end
      fillCnt_reg <= fillCnt_reg + {{PTR_W{1'b0}}, rxPush}
        - {{PTR_W{1'b0}}, rxPop}; // [R6] [R12]
    end
  end

  // Overrun holds reception until software drops the continuous receive enable or the port enable.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      overrun_reg <= 1'b0;
    end else if (rxOverflow) begin
      overrun_reg <= 1'b1; // [R7]
    end else if (portReset || !contEn) begin
      overrun_reg <= 1'b0; // [R7]
    end
  end

  // Transmit holding buffer; the set from software wins over a move out.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txBuf_reg <= `WORD_RESET;
      txBufFull_reg <= 1'b0;
    end else if (portReset) begin
      txBuf_reg <= `WORD_RESET;
      txBufFull_reg <= 1'b0;
    end else if (wrTxData) begin
      txBuf_reg <= txWord;
      txBufFull_reg <= 1'b1; // [R17]
    end else if (txLoad) begin
      txBufFull_reg <= 1'b0; // [R16]
    end
  end

  // Transmit shift register; the first bit is presented at load.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txState_reg <= sync_slave_pkg::TX_IDLE;
      txShift_reg <= `WORD_RESET;
      txCnt_reg <= '0;
    end else if (portReset || !txModeSel) begin
      txState_reg <= sync_slave_pkg::TX_IDLE;
      txShift_reg <= `WORD_RESET;
      txCnt_reg <= '0;
    end else begin
      case (txState_reg)
        sync_slave_pkg::TX_IDLE: begin
          if (txLoad) begin
            txShift_reg <= txBuf_reg;
            txCnt_reg <= '0;
            txState_reg <= sync_slave_pkg::TX_SHIFTING;
          end
        end
        sync_slave_pkg::TX_SHIFTING: begin
          if (txWordDone) begin
            // The next word follows with no gap when the buffer holds one.
            txShift_reg <= txBuf_reg; // [R16]
            txCnt_reg <= '0;
            txState_reg <= txLoad ? sync_slave_pkg::TX_SHIFTING :
              sync_slave_pkg::TX_IDLE;
          end else if (sampleEdge) begin
            txCnt_reg <= txCnt_reg + 4'h1; // [R21]
          end else if (launchEdge && txCnt_reg != '0) begin
            txShift_reg <= {1'b0, txShift_reg[8:1]}; // [R9] [R21]
          end
        end
        default: begin
          txState_reg <= sync_slave_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Data pin drive and wake outputs come from flip-flops.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      serialDataOut <= 1'b0;
      serialDataOe <= 1'b0;
      wakeRequest <= 1'b0;
      vectorCall <= 1'b0;
    end else begin
      serialDataOut <= txShift_reg[0];
      serialDataOe <= txModeSel;
      // Wake leaves sleep at the next instruction; the vector call needs
      // the global enable on top.
      wakeRequest <= periphIrq && sleepMode; // [R12] [R13]
      vectorCall <= vectorNext; // [R13]
    end
  end

endmodule // sync_slave_serial_port
`default_nettype wire

// [test/sync_slave_sva.sv]
// Checker of register answers, pin mode and wake outputs of the serial port.
`timescale 1ns/1ns
`default_nettype none
`include "sync_slave_defs.svh"
module sync_slave_sva #(
  parameter int RX_DEPTH = 2
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port.
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Pins and power state.
  input wire logic serialDataOe,
  input wire logic sleepMode,
  input wire logic wakeRequest,
  input wire logic vectorCall
);
  logic [7:0] rxCtrl_reg, txCtrl_reg, irqCtrl_reg;
  logic txMode;
  // Whole written bytes are shadowed, but only bits 7 to 4 are compared; the port's own flags are judged by the bench.
  assign txMode = rxCtrl_reg[7] & txCtrl_reg[4] & ~txCtrl_reg[7] & txCtrl_reg[5] & ~|rxCtrl_reg[5:4];
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxCtrl_reg <= 8'h00;
      txCtrl_reg <= 8'h00;
      irqCtrl_reg <= 8'h00;
    end else if (regWrite) begin
      if (regAddr == `RX_CTRL_IDX) rxCtrl_reg <= regWrData;
      if (regAddr == `TX_CTRL_IDX) txCtrl_reg <= regWrData;
      if (regAddr == `IRQ_CTRL_IDX) irqCtrl_reg <= regWrData;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_rd_idle;
    !$past(regRead) |-> regRdData == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
  property p_rd_once;
    regRead ##1 !regRead |=> regRdData == 8'h00;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read data held too long");
  property p_unmapped;
    regRead && regAddr > 3'h5 |=> regRdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped place read nonzero");
  property p_txdata_wo;
    regRead && regAddr == `TX_DATA_IDX |=> regRdData == 8'h00;
  endproperty
  a_txdata_wo: assert property (p_txdata_wo) else $error("transmit data read nonzero");
  property p_rx_ctrl;
    regRead && regAddr == `RX_CTRL_IDX |=> regRdData[7:4] == $past(rxCtrl_reg[7:4]);
  endproperty
  a_rx_ctrl: assert property (p_rx_ctrl) else $error("receive control readback wrong");
  property p_tx_ctrl;
    regRead && regAddr == `TX_CTRL_IDX |=> regRdData[7:4] == $past(txCtrl_reg[7:4]);
  endproperty
  a_tx_ctrl: assert property (p_tx_ctrl) else $error("transmit control readback wrong");
  property p_irq_ctrl;
    regRead && regAddr == `IRQ_CTRL_IDX |=> regRdData[7:4] == $past(irqCtrl_reg[7:4]);
  endproperty
  a_irq_ctrl: assert property (p_irq_ctrl) else $error("irq enable readback wrong");
  property p_vector;
    vectorCall |-> $past(irqCtrl_reg[7:6] == 2'b11 && |irqCtrl_reg[5:4]);
  endproperty
  a_vector: assert property (p_vector) else $error("vector call without enables");
  property p_wake;
    wakeRequest |-> $past(sleepMode && irqCtrl_reg[6]);
  endproperty
  a_wake: assert property (p_wake) else $error("wake outside sleep");
  property p_drive;
    serialDataOe |-> $past(txMode);
  endproperty
  a_drive: assert property (p_drive) else $error("data pin driven outside transmit");
endmodule // sync_slave_sva
bind sync_slave_serial_port sync_slave_sva #(.RX_DEPTH(RX_DEPTH)) sync_slave_sva_i (
  .sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .serialDataOe(serialDataOe),
  .sleepMode(sleepMode), .wakeRequest(wakeRequest), .vectorCall(vectorCall));
`default_nettype wire

// [test/sync_master_model.sv]
// Model of the external master that clocks the serial port.
`timescale 1ns/1ns
`default_nettype none
module sync_master_model (
  // Serial pins.
  output logic serialClk,
  output logic dataOut,
  output logic dataDrive,
  input wire logic dataIn
);
  logic pol = 1'b0;
  initial begin
    serialClk = 1'b0;
    dataOut = 1'b0;
    dataDrive = 1'b0;
  end
  // Change the idle level only while the port is off, or it sees a stray edge.
  task automatic idle(input logic p);
    pol = p;
    serialClk = p;
  endtask
  // The clock rests between frames; a larger slow value stretches each bit.
  task automatic xfer(input int nb, input logic [8:0] v, input logic drv, input int slow,
                      output logic [8:0] got);
    got = 9'h000;
    for (int i = 0; i < nb; i++) begin
      dataDrive = drv;
      dataOut = v[i];
      #(80 + slow);
      serialClk = !pol;
      got[i] = dataIn;
      #80;
      serialClk = pol;
    end
    #80;
    dataDrive = 1'b0;
  endtask
endmodule // sync_master_model
`default_nettype wire

// [test/tb.sv]
// Self-checking bench of the synchronous slave serial port.
`timescale 1ns/1ns
`default_nettype none
`include "sync_slave_defs.svh"
module tb;
  logic sys_clk, nrst, regWrite, regRead, sleepMode, serialClk, mOut, mDrive, ovr;
  logic serialDataOut, serialDataOe, wakeRequest, vectorCall;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, rd, b0, b1;
  logic [8:0] got;
  logic [8:0] rxq[$];
  wire logic dataWire;
  int n_fail = 0;
  int n_checks = 0;
  // A released pin shows the inverse of its last level, so stale data cannot match.
  assign dataWire = serialDataOe ? serialDataOut : (mDrive ? mOut : !mOut);
  sync_slave_serial_port #(.RX_DEPTH(2)) sync_slave_serial_port_i (
    .sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .serialClkPin(serialClk),
    .serialDataIn(dataWire), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
    .sleepMode(sleepMode), .wakeRequest(wakeRequest), .vectorCall(vectorCall));
  sync_master_model sync_master_model_i (
    .serialClk(serialClk), .dataOut(mOut), .dataDrive(mDrive), .dataIn(dataWire));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdreg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  // Reference receive FIFO of depth two; a word arriving when full is lost for good.
  task automatic send(input logic [8:0] v, input int nb, input int slow);
    sync_master_model_i.xfer(nb, v, 1'b1, slow, got);
    if (ovr || rxq.size() >= 2) ovr = 1'b1;
    else rxq.push_back(nb == 9 ? v : {1'b0, v[7:0]});
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic take();
    logic [8:0] e;
    e = rxq.pop_front();
    rdreg(`RX_CTRL_IDX, rd);
    chk(rd[0], e[8]);
    rdreg(`RX_DATA_IDX, rd);
    chk(rd, e[7:0]);
  endtask
  task automatic recv(input logic [7:0] b);
    sync_master_model_i.xfer(8, 9'h000, 1'b0, 0, got);
    chk(got[7:0], b);
    repeat (8) @(posedge sys_clk);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = !sys_clk;
  end
  initial begin
    #400000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    {nrst, regWrite, regRead, sleepMode, ovr, regAddr, regWrData} = '0;
    void'($urandom(58));
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    wr(3'h6, 8'hFF);
    wr(`RX_DATA_IDX, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      if (a != 2 && a != 5) rdreg(a[2:0], rd);
      if (a != 2 && a != 5) chk(rd, (a == 1) ? 9'h002 : 9'h000);
    end
    wr(`TX_CTRL_IDX, 8'h10);
    wr(`IRQ_CTRL_IDX, 8'hE0);
    wr(`RX_CTRL_IDX, 8'hB0);
    for (int i = 0; i < 3; i++) begin
      send(9'($urandom()), 8, i * 60);
      chk(vectorCall, 1'b1);
      take();
    end
    wr(`RX_CTRL_IDX, 8'hD0);
    send(9'($urandom()), 9, 0);
    take();
    wr(`RX_CTRL_IDX, 8'h90);
    wr(`IRQ_CTRL_IDX, 8'h60);
    send(9'($urandom()), 8, 0);
    chk(vectorCall, 1'b0);
    take();
    @(posedge sys_clk);
    sleepMode <= 1'b1;
    send(9'($urandom()), 8, 0);
    chk(wakeRequest, 1'b1);
    @(posedge sys_clk);
    sleepMode <= 1'b0;
    take();
    for (int i = 0; i < 4; i++) send(9'($urandom()), 8, 0);
    rdreg(`RX_CTRL_IDX, rd);
    chk(rd[1], 1'b1);
    take();
    take();
    rdreg(`IRQ_CTRL_IDX, rd);
    chk(rd[1], 1'b0);
    rdreg(`RX_CTRL_IDX, rd);
    chk(rd[1], 1'b1);
    wr(`RX_CTRL_IDX, 8'h80);
    ovr = 1'b0;
    rdreg(`RX_CTRL_IDX, rd);
    chk(rd[1], 1'b0);
    wr(`TX_CTRL_IDX, 8'h30);
    wr(`IRQ_CTRL_IDX, 8'h50);
    b0 = 8'($urandom());
    b1 = 8'($urandom());
    wr(`TX_DATA_IDX, b0);
    wr(`TX_DATA_IDX, b1);
    rdreg(`IRQ_CTRL_IDX, rd);
    chk(rd[0], 1'b0);
    @(posedge sys_clk);
    sleepMode <= 1'b1;
    recv(b0);
    chk(wakeRequest, 1'b1);
    rdreg(`IRQ_CTRL_IDX, rd);
    chk(rd[0], 1'b1);
    recv(b1);
    sleepMode <= 1'b0;
    wr(`RX_CTRL_IDX, 8'h00);
    wr(`BAUD_CTRL_IDX, 8'h10);
    sync_master_model_i.idle(1'b1);
    wr(`RX_CTRL_IDX, 8'h80);
    wr(`TX_DATA_IDX, b1 ^ 8'h5A);
    recv(b1 ^ 8'h5A);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
